// file: src/vipc_irq_ctrl.v
// Vectored interrupt controller with four programmable priority levels.
// Assumes the core marks the last cycle of each instruction and whether
// that instruction returns from an interrupt or writes an enable or
// priority register; all inputs are synchronous to mclk.
//
// Functional notes
// - First four sources each have one flag and vector.
// - Remaining vectors; 0053H reserved; reset at zero.
// - Shared vectors request on OR of flags.
// - Each source needs its own enable bit.
// - Cleared global enable blocks every source.
// - Software flag writes act like hardware.
// - Four levels from a low and high bit.
// - Level is high bit then low bit.
// - Preempt only by strictly higher level.
// - Level three service is never preempted.
// - Higher pending level is selected first.
// - Equal level: earlier polling order wins.
// - Counter array polled fifth, before serial.
// - Polling order never overrides programmed level.
// - Poll at instruction end; no memory.
// - Hold off after return or register write.
// - Clear timer 0/1 and edge external flags on vector.
// - Hardware call lasts four clock cycles.
`include "vipc_defs.vh"

module vipc_irq_ctrl
(
   // Clock and reset
   input  wire        mclk,
   input  wire        nrst,
   // Core handshake
   input  wire        instr_last,
   input  wire        instr_blocks,
   input  wire        return_from_irq,
   // Enable and priority registers
   input  wire [7:0]  irq_enable_reg_a,
   input  wire [7:0]  irq_enable_reg_b,
   input  wire [7:0]  priority_low_bits_a,
   input  wire [7:0]  priority_low_bits_b,
   input  wire [7:0]  priority_high_bits_a,
   input  wire [7:0]  priority_high_bits_b,
   // External request configuration, one for edge-triggered
   input  wire        ext_a_edge_mode,
   input  wire        ext_b_edge_mode,
   // Request flags, set or cleared by hardware or software alike
   input  wire        ext_request_flag_a,
   input  wire        ext_request_flag_b,
   input  wire        timer0_overflow_flag,
   input  wire        timer1_overflow_flag,
   input  wire        timer2_overflow_flag,
   input  wire        timer2_external_flag,
   input  wire        uart_rx_done_flag,
   input  wire        uart_tx_done_flag,
   input  wire        counter_array_overflow_flag,
   input  wire [4:0]  counter_module_flags,
   input  wire [7:0]  keypad_flags,
   input  wire        twi_flag,
   input  wire        spi_transfer_done_flag,
   input  wire        spi_mode_fault_flag,
   input  wire        spi_tx_empty_flag,
   input  wire        comparator_a_flag,
   input  wire        comparator_b_flag,
   input  wire        adc_done_flag,
   // Vector to the core
   output reg         call_busy_r,
   output reg         vec_valid_r,
   output reg  [15:0] vec_addr_r,
   // Flag clears to the owning peripherals, one-cycle pulses
   output reg         clr_ext_a_r,
   output reg         clr_ext_b_r,
   output reg         clr_tmr0_r,
   output reg         clr_tmr1_r,
   // Levels in service, bit n for level n
   output reg  [3:0]  in_service_r
);

   // ****************************************************************
   // Request gathering
   // ****************************************************************
   // Registered copy: the poll sees the previous cycle's flags.
   reg  [11:0] raw_r;
   wire [11:0] raw;
   wire [11:0] ena;
   wire [11:0] req;
   wire [23:0] lvl;
   wire        gen;

   assign raw = {adc_done_flag,
                 comparator_a_flag | comparator_b_flag,
                 spi_transfer_done_flag | spi_mode_fault_flag |
                    spi_tx_empty_flag,
                 twi_flag,
                 |keypad_flags,
                 timer2_overflow_flag | timer2_external_flag,
                 uart_rx_done_flag | uart_tx_done_flag,
                 counter_array_overflow_flag | (|counter_module_flags),
                 timer1_overflow_flag,
                 ext_request_flag_b,
                 timer0_overflow_flag,
                 ext_request_flag_a};

   assign ena = {irq_enable_reg_b[`VIPC_ENB_ADC],
                 irq_enable_reg_b[`VIPC_ENB_CMP],
                 irq_enable_reg_b[`VIPC_ENB_SPI],
                 irq_enable_reg_b[`VIPC_ENB_TWI],
                 irq_enable_reg_b[`VIPC_ENB_KEYPAD],
                 irq_enable_reg_a[`VIPC_ENA_TMR2],
                 irq_enable_reg_a[`VIPC_ENA_UART],
                 irq_enable_reg_a[`VIPC_ENA_CNTARR],
                 irq_enable_reg_a[`VIPC_ENA_TMR1],
                 irq_enable_reg_a[`VIPC_ENA_EXT_B],
                 irq_enable_reg_a[`VIPC_ENA_TMR0],
                 irq_enable_reg_a[`VIPC_ENA_EXT_A]};

   assign gen = irq_enable_reg_a[`VIPC_ENA_GLOBAL];
   assign req = raw_r & ena & {12{gen}};

   // level from low and high bit
   // high bit is the upper bit
   assign lvl = {priority_high_bits_b[5], priority_low_bits_b[5],
                 priority_high_bits_b[4], priority_low_bits_b[4],
                 priority_high_bits_b[2], priority_low_bits_b[2],
                 priority_high_bits_b[1], priority_low_bits_b[1],
                 priority_high_bits_b[0], priority_low_bits_b[0],
                 priority_high_bits_a[5], priority_low_bits_a[5],
                 priority_high_bits_a[4], priority_low_bits_a[4],
                 priority_high_bits_a[6], priority_low_bits_a[6],
                 priority_high_bits_a[3], priority_low_bits_a[3],
                 priority_high_bits_a[2], priority_low_bits_a[2],
                 priority_high_bits_a[1], priority_low_bits_a[1],
                 priority_high_bits_a[0], priority_low_bits_a[0]};

   // ****************************************************************
   // Arbitration
   // ****************************************************************
   wire       hit;
   wire [3:0] idx;
   wire [1:0] win_lvl;

   vipc_level_pick u_pick
   (
      .req     (req),
      .lvl     (lvl),
      .hit     (hit),
      .idx     (idx),
      .win_lvl (win_lvl)
   );

   reg [3:0] above;
   always @*
   begin
      case (win_lvl)
         2'h0:    above = 4'hf;
         2'h1:    above = 4'he;
         2'h2:    above = 4'hc;
         default: above = 4'h8;
      endcase
   end

   wire take = instr_last && !instr_blocks && hit && !call_busy_r &&
               ((in_service_r & above) == 4'h0);

   reg [15:0] vec_nxt;
   always @*
   begin
      case (idx)
         `VIPC_SRC_EXT_A:  vec_nxt = `VIPC_VEC_EXT_A;
         `VIPC_SRC_TMR0:   vec_nxt = `VIPC_VEC_TMR0;
         `VIPC_SRC_EXT_B:  vec_nxt = `VIPC_VEC_EXT_B;
         `VIPC_SRC_TMR1:   vec_nxt = `VIPC_VEC_TMR1;
         `VIPC_SRC_CNTARR: vec_nxt = `VIPC_VEC_CNTARR;
         `VIPC_SRC_UART:   vec_nxt = `VIPC_VEC_UART;
         `VIPC_SRC_TMR2:   vec_nxt = `VIPC_VEC_TMR2;
         `VIPC_SRC_KEYPAD: vec_nxt = `VIPC_VEC_KEYPAD;
         `VIPC_SRC_TWI:    vec_nxt = `VIPC_VEC_TWI;
         `VIPC_SRC_SPI:    vec_nxt = `VIPC_VEC_SPI;
         `VIPC_SRC_CMP:    vec_nxt = `VIPC_VEC_CMP;
         `VIPC_SRC_ADC:    vec_nxt = `VIPC_VEC_ADC;
         default:          vec_nxt = `VIPC_VEC_RESET;
      endcase
   end

   // ****************************************************************
   // Hardware call sequence and service tracking
   // ****************************************************************
   localparam ST_IDLE = 1'b0;
   localparam ST_CALL = 1'b1;

   reg [2:0] cnt_r;
   reg [3:0] ret_mask;

   // Highest active level is released first on return.
   always @*
   begin
      if (in_service_r[3])
         ret_mask = 4'h8;
      else if (in_service_r[2])
         ret_mask = 4'h4;
      else if (in_service_r[1])
         ret_mask = 4'h2;
      else
         ret_mask = in_service_r & 4'h1;
   end

   always @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         raw_r        <= 12'h000;
         call_busy_r  <= ST_IDLE;
         cnt_r        <= 3'h0;
         vec_valid_r  <= 1'b0;
         vec_addr_r   <= `VIPC_VEC_RESET;
         clr_ext_a_r  <= 1'b0;
         clr_ext_b_r  <= 1'b0;
         clr_tmr0_r   <= 1'b0;
         clr_tmr1_r   <= 1'b0;
         in_service_r <= 4'h0;
      end
      else
      begin
         raw_r       <= raw;
         clr_ext_a_r <= 1'b0;
         clr_ext_b_r <= 1'b0;
         clr_tmr0_r  <= 1'b0;
         clr_tmr1_r  <= 1'b0;
         vec_valid_r <= 1'b0;
         case (call_busy_r)
            ST_IDLE:
            begin
               if (return_from_irq)
               begin
                  in_service_r <= in_service_r & ~ret_mask;
               end
               if (take)
               begin
                  call_busy_r  <= ST_CALL;
                  cnt_r        <= `VIPC_CALL_CYCLES - 3'h1;
                  vec_valid_r  <= 1'b1;
                  vec_addr_r   <= vec_nxt;
                  in_service_r <= (in_service_r &
                                   ~({4{return_from_irq}} & ret_mask)) |
                                  (4'h1 << win_lvl);
                  clr_ext_a_r  <= (idx == `VIPC_SRC_EXT_A) &&
                                  ext_a_edge_mode;
                  clr_ext_b_r  <= (idx == `VIPC_SRC_EXT_B) &&
                                  ext_b_edge_mode;
                  clr_tmr0_r   <= (idx == `VIPC_SRC_TMR0);
                  clr_tmr1_r   <= (idx == `VIPC_SRC_TMR1);
               end
            end
            ST_CALL:
            begin
               // four-cycle call
               // Counting three down to zero keeps the call busy for
               // four edges, so no new take can cut the call short.
               if (cnt_r == 3'h0)
                  call_busy_r <= ST_IDLE;
               else
                  cnt_r <= cnt_r - 3'h1;
            end
            default:
               call_busy_r <= ST_IDLE;
         endcase
      end
   end

endmodule // vipc_irq_ctrl

// file: common/vipc_defs.vh
// Constants for the vectored interrupt priority controller.
// Assumes inclusion by the design files only; no logic lives here.
`ifndef VIPC_DEFS_VH
`define VIPC_DEFS_VH

// ****************************************************************
// Source indices in polling order
// ****************************************************************
`define VIPC_NSRC        12
`define VIPC_SRC_EXT_A   4'h0
`define VIPC_SRC_TMR0    4'h1
`define VIPC_SRC_EXT_B   4'h2
`define VIPC_SRC_TMR1    4'h3
`define VIPC_SRC_CNTARR  4'h4
`define VIPC_SRC_UART    4'h5
`define VIPC_SRC_TMR2    4'h6
`define VIPC_SRC_KEYPAD  4'h7
`define VIPC_SRC_TWI     4'h8
`define VIPC_SRC_SPI     4'h9
`define VIPC_SRC_CMP     4'ha
`define VIPC_SRC_ADC     4'hb

// ****************************************************************
// Vector addresses
// ****************************************************************
`define VIPC_VEC_RESET   16'h0000
`define VIPC_VEC_EXT_A   16'h0003
`define VIPC_VEC_TMR0    16'h000b
`define VIPC_VEC_EXT_B   16'h0013
`define VIPC_VEC_TMR1    16'h001b
`define VIPC_VEC_UART    16'h0023
`define VIPC_VEC_TMR2    16'h002b
`define VIPC_VEC_CNTARR  16'h0033
`define VIPC_VEC_KEYPAD  16'h003b
`define VIPC_VEC_TWI     16'h0043
`define VIPC_VEC_SPI     16'h004b
`define VIPC_VEC_RSVD    16'h0053
`define VIPC_VEC_CMP     16'h005b
`define VIPC_VEC_ADC     16'h0063

// ****************************************************************
// Enable register bit positions
// ****************************************************************
`define VIPC_ENA_GLOBAL  7
`define VIPC_ENA_CNTARR  6
`define VIPC_ENA_TMR2    5
`define VIPC_ENA_UART    4
`define VIPC_ENA_TMR1    3
`define VIPC_ENA_EXT_B   2
`define VIPC_ENA_TMR0    1
`define VIPC_ENA_EXT_A   0
`define VIPC_ENB_ADC     5
`define VIPC_ENB_CMP     4
`define VIPC_ENB_SPI     2
`define VIPC_ENB_TWI     1
`define VIPC_ENB_KEYPAD  0

// ****************************************************************
// Timing
// ****************************************************************
`define VIPC_CALL_CYCLES 3'h4

`endif

// file: src/vipc_level_pick.v
// Two-stage arbiter: highest level first, polling order among equals.
// Assumes requests are already gated by the enables.
`include "vipc_defs.vh"

module vipc_level_pick
(
   // Gated requests and their levels, two bits per source
   input  wire [11:0] req,
   input  wire [23:0] lvl,
   // Winner
   output reg         hit,
   output reg  [3:0]  idx,
   output reg  [1:0]  win_lvl
);

   integer i;
   reg [1:0] best;

   always @*
   begin
      best    = 2'h0;
      hit     = 1'b0;
      idx     = 4'h0;
      win_lvl = 2'h0;
      for (i = 0; i < 12; i = i + 1)
      begin
         if (req[i] && (!hit || lvl[2*i +: 2] > best))
         begin
            best = lvl[2*i +: 2];
            hit  = 1'b1;
         end
      end
      // polling only breaks ties of level
      for (i = 11; i >= 0; i = i - 1)
      begin
         if (req[i] && lvl[2*i +: 2] == best)
         begin
            idx = i[3:0];
         end
      end
      win_lvl = best;
   end

endmodule // vipc_level_pick

// file: verification/vipc_irq_checker_assertions.sv
// Port-level assertions for the vectored interrupt controller.
// Assumes only the controller ports; attached by the bind at the foot.
module vipc_irq_checker
(
   // Clock and reset
   input wire logic        mclk,
   input wire logic        nrst,
   // Core handshake and controls
   input wire logic        instr_last,
   input wire logic        instr_blocks,
   input wire logic        return_from_irq,
   input wire logic [7:0]  irq_enable_reg_a,
   input wire logic        ext_a_edge_mode,
   // Controller outputs
   input wire logic        call_busy_r,
   input wire logic        vec_valid_r,
   input wire logic [15:0] vec_addr_r,
   input wire logic        clr_ext_a_r,
   input wire logic        clr_tmr0_r,
   input wire logic        clr_tmr1_r,
   input wire logic [3:0]  in_service_r
);
   timeunit 1ns;
   timeprecision 1ps;
   // *****
   // Properties
   // *****
   default clocking @(posedge mclk); endclocking
   default disable iff (!nrst);
   sequence s_call;
      call_busy_r [*4] ##1 !call_busy_r;
   endsequence
   sequence s_taken;
      $past(instr_last) && !$past(instr_blocks) && !$past(call_busy_r);
   endsequence
   a_call_four: assert property (vec_valid_r |-> s_call)
      else $error("Call busy not four cycles");
   a_valid_pulse: assert property (vec_valid_r |=> !vec_valid_r)
      else $error("Vector valid longer than one cycle");
   a_take_point: assert property (vec_valid_r |-> s_taken)
      else $error("Vector taken outside an open poll");
   a_vec_legal: assert property (vec_valid_r |-> vec_addr_r inside
      {16'h0003, 16'h000b, 16'h0013, 16'h001b, 16'h0023, 16'h002b,
       16'h0033, 16'h003b, 16'h0043, 16'h004b, 16'h005b, 16'h0063})
      else $error("Vector address not legal");
   a_global_gate: assert property (!$past(irq_enable_reg_a[7])
      |-> !vec_valid_r)
      else $error("Vector with global enable clear");
   a_clr_timers: assert property (
      clr_tmr0_r == (vec_valid_r && vec_addr_r == 16'h000b) &&
      clr_tmr1_r == (vec_valid_r && vec_addr_r == 16'h001b))
      else $error("Timer flag clear mismatch");
   a_clr_ext: assert property (clr_ext_a_r == (vec_valid_r &&
      vec_addr_r == 16'h0003 && $past(ext_a_edge_mode)))
      else $error("External flag clear mismatch");
   a_new_higher: assert property (vec_valid_r |->
      $past(in_service_r) < (in_service_r & ~$past(in_service_r)))
      else $error("Vector not above levels in service");
   a_top_held: assert property ($past(in_service_r[3])
      |-> !vec_valid_r)
      else $error("Level three service preempted");
   a_ret_top: assert property (return_from_irq && !call_busy_r &&
      in_service_r[3] |=> in_service_r == ($past(in_service_r) & 4'h7))
      else $error("Return did not release level three");
endmodule // vipc_irq_checker

bind vipc_irq_ctrl vipc_irq_checker u_vipc_irq_checker
(
   .mclk, .nrst, .instr_last, .instr_blocks, .return_from_irq,
   .irq_enable_reg_a, .ext_a_edge_mode, .call_busy_r, .vec_valid_r,
   .vec_addr_r, .clr_ext_a_r, .clr_tmr0_r, .clr_tmr1_r, .in_service_r
);

// file: verification/vipc_core_model.sv
// Behavioural core: ends an instruction every third cycle.
// Assumes the bench raises its requests at rising edges.
module vipc_core_model
(
   // Clock and reset
   input  wire logic mclk,
   input  wire logic nrst,
   // Requests from the bench
   input  wire logic blk_req,
   input  wire logic ret_req,
   // Handshake to the controller
   output logic      instr_last,
   output logic      instr_blocks,
   output logic      return_from_irq
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] cnt_r;
   logic       pend_r;
   wire        end_nxt = (cnt_r == 2'h1);
   // A return is held until the end of the next instruction.
   always @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         cnt_r <= 2'h0;
         pend_r <= 1'b0;
         {instr_last, instr_blocks, return_from_irq} <= 3'h0;
      end
      else
      begin
         cnt_r <= (cnt_r == 2'h2) ? 2'h0 : cnt_r + 2'h1;
         pend_r <= (pend_r | ret_req) & !end_nxt;
         instr_last <= end_nxt;
         instr_blocks <= end_nxt & (blk_req | pend_r | ret_req);
         return_from_irq <= end_nxt & (pend_r | ret_req);
      end
   end
endmodule // vipc_core_model

// file: verification/vipc_irq_ctrl_tb.sv
// Self-checking bench for the vectored interrupt controller.
// Assumes the core model drives the handshake; flags come from here.
module vipc_irq_ctrl_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        mclk, nrst, blk_req, ret_req, ema, emb;
   logic [28:0] fl;
   logic [15:0] en, pl, ph, vec_addr_r;
   logic        instr_last, instr_blocks, return_from_irq;
   logic        call_busy_r, vec_valid_r;
   logic        clr_ext_a_r, clr_ext_b_r, clr_tmr0_r, clr_tmr1_r;
   logic [3:0]  in_service_r;
   int          bad_count, n_tests;
   vipc_core_model u_vipc_core_model
   (
      .mclk, .nrst, .blk_req, .ret_req, .instr_last, .instr_blocks,
      .return_from_irq
   );
   vipc_irq_ctrl u_vipc_irq_ctrl
   (
      .mclk, .nrst, .instr_last, .instr_blocks, .return_from_irq,
      .irq_enable_reg_a(en[7:0]), .irq_enable_reg_b(en[15:8]),
      .priority_low_bits_a(pl[7:0]), .priority_low_bits_b(pl[15:8]),
      .priority_high_bits_a(ph[7:0]), .priority_high_bits_b(ph[15:8]),
      .ext_a_edge_mode(ema), .ext_b_edge_mode(emb),
      .ext_request_flag_a(fl[0]), .timer0_overflow_flag(fl[1]),
      .ext_request_flag_b(fl[2]), .timer1_overflow_flag(fl[3]),
      .uart_rx_done_flag(fl[4]), .uart_tx_done_flag(fl[5]),
      .timer2_overflow_flag(fl[6]), .timer2_external_flag(fl[7]),
      .counter_array_overflow_flag(fl[8]),
      .counter_module_flags(fl[13:9]), .keypad_flags(fl[21:14]),
      .twi_flag(fl[22]), .spi_transfer_done_flag(fl[23]),
      .spi_mode_fault_flag(fl[24]), .spi_tx_empty_flag(fl[25]),
      .comparator_a_flag(fl[26]), .comparator_b_flag(fl[27]),
      .adc_done_flag(fl[28]), .call_busy_r, .vec_valid_r, .vec_addr_r,
      .clr_ext_a_r, .clr_ext_b_r, .clr_tmr0_r, .clr_tmr1_r, .in_service_r
   );
   initial
   begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end
   // *****
   // Shared tasks
   // *****
   task automatic end_sim;
      $display("Checks %0d, mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         bad_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic no_vec(input int n);
      repeat (n)
      begin
         @(posedge mclk);
         #1;
         chk({15'h0, vec_valid_r}, 16'h0);
      end
   endtask
   // A hang here ends the run rather than stalling it.
   task automatic wait_vec(input logic [15:0] exp);
      int i;
      for (i = 0; i < 40; i++)
      begin
         @(posedge mclk);
         #1;
         if (vec_valid_r === 1'b1)
            break;
      end
      if (i == 40)
      begin
         bad_count++;
         $display("Error at %0t: got none expected %h", $time, exp);
         end_sim;
      end
      else
         chk(vec_addr_r, exp);
   endtask
   // Waits out the call first: a return during it is ignored.
   task automatic ret_irq;
      repeat (4) @(posedge mclk);
      ret_req <= 1'b1;
      @(posedge mclk);
      ret_req <= 1'b0;
      repeat (6) @(posedge mclk);
      #1;
   endtask
   function automatic logic [19:0] vmap(input int j);
      case (j) inside
         0: vmap = {4'h0, 16'h0003};
         1: vmap = {4'h1, 16'h000b};
         2: vmap = {4'h2, 16'h0013};
         3: vmap = {4'h3, 16'h001b};
         [4:5]: vmap = {4'h4, 16'h0023};
         [6:7]: vmap = {4'h5, 16'h002b};
         [8:13]: vmap = {4'h6, 16'h0033};
         [14:21]: vmap = {4'h8, 16'h003b};
         22: vmap = {4'h9, 16'h0043};
         [23:25]: vmap = {4'ha, 16'h004b};
         [26:27]: vmap = {4'hc, 16'h005b};
         default: vmap = {4'hd, 16'h0063};
      endcase
   endfunction
   // *****
   // Scenarios
   // *****
   task automatic t_reset;
      #1;
      chk({call_busy_r, vec_valid_r, clr_ext_a_r, in_service_r}, 0);
      chk(vec_addr_r, 16'h0000);
      @(posedge mclk);
      nrst <= 1'b1;
   endtask
   task automatic t_sources;
      logic [19:0] m;
      logic [3:0]  c;
      for (int j = 0; j < 29; j++)
      begin
         m = vmap(j);
         c = (j >= 1 && j <= 3) ? (4'h1 << j) : 4'h0;
         @(posedge mclk);
         en <= 16'h0080;
         fl <= 29'h1 << j;
         no_vec(12);
         @(posedge mclk);
         en <= 16'h0080 | (16'h1 << m[19:16]);
         wait_vec(m[15:0]);
         chk({12'h0, clr_tmr1_r, clr_ext_b_r, clr_tmr0_r, clr_ext_a_r},
             {12'h0, c});
         chk({12'h0, in_service_r}, 16'h1);
         @(posedge mclk);
         fl <= '0;
         ret_irq;
         chk({12'h0, in_service_r}, 16'h0);
      end
   endtask
   task automatic t_global;
      @(posedge mclk);
      en <= 16'h3f7f;
      fl <= 29'h1fffffff;
      no_vec(15);
      @(posedge mclk);
      fl <= '0;
      // The poll's copy of the flags lags one edge; let it drain first.
      repeat (2) @(posedge mclk);
      en <= 16'h3fff;
   endtask
   task automatic t_poll;
      logic [28:0] f [3] = '{29'h1fffffff, 29'h150, 29'h1fc00000};
      logic [15:0] a [3] = '{16'h0003, 16'h0033, 16'h0043};
      for (int k = 0; k < 3; k++)
      begin
         @(posedge mclk);
         fl <= f[k];
         wait_vec(a[k]);
         @(posedge mclk);
         fl <= '0;
         ret_irq;
      end
   endtask
   task automatic t_levels;
      logic [1:0] h, l;
      for (int v = 1; v < 4; v++)
      begin
         h = 2'(v);
         l = 2'(v - 1);
         @(posedge mclk);
         pl <= {2'b0, h[0], 11'h0, h[0], l[0]};
         ph <= {2'b0, h[1], 11'h0, h[1], l[1]};
         ema <= 1'b1;
         fl <= 29'h1;
         wait_vec(16'h0003);
         chk({15'h0, clr_ext_a_r}, 16'h1);
         chk({12'h0, in_service_r}, {12'h0, 4'h1 << l});
         @(posedge mclk);
         fl <= 29'h10000000;
         wait_vec(16'h0063);
         @(posedge mclk);
         fl <= 29'h2;
         no_vec(15);
         @(posedge mclk);
         fl <= '0;
         ret_irq;
         ret_irq;
         chk({12'h0, in_service_r}, 16'h0);
         @(posedge mclk);
         fl <= 29'h3;
         wait_vec(16'h000b);
         @(posedge mclk);
         fl <= '0;
         ret_irq;
      end
   endtask
   task automatic t_block;
      @(posedge mclk);
      pl <= '0;
      ph <= '0;
      blk_req <= 1'b1;
      fl <= 29'h10000000;
      no_vec(15);
      @(posedge mclk);
      fl <= '0;
      blk_req <= 1'b0;
      no_vec(15);
   endtask
   // A reset in mid-service must drop every record at once.
   task automatic t_mid_reset;
      @(posedge mclk);
      fl <= 29'h1;
      wait_vec(16'h0003);
      @(posedge mclk);
      nrst <= 1'b0;
      fl <= '0;
      @(posedge mclk);
      #1;
      chk({10'h0, call_busy_r, vec_valid_r, in_service_r}, 16'h0);
      @(posedge mclk);
      nrst <= 1'b1;
      no_vec(6);
   endtask
   initial
   begin
      nrst = 1'b0;
      blk_req = 1'b0;
      ret_req = 1'b0;
      ema = 1'b0;
      emb = 1'b1;
      fl = '0;
      en = '0;
      pl = '0;
      ph = '0;
      bad_count = 0;
      n_tests = 0;
      repeat (8) @(posedge mclk);
      t_reset;
      t_sources;
      t_global;
      t_poll;
      t_levels;
      t_block;
      t_mid_reset;
      end_sim;
   end
endmodule // vipc_irq_ctrl_tb
